// ---- src/nand_host_pkg.sv ----
// Package of constants shared by the NAND host controller files.
`default_nettype none
package nand_host_pkg;
  localparam logic [7:0] CMD_READ_LOW = 8'h00;
  localparam logic [7:0] CMD_READ_HIGH = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE = 8'h50;
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_PROGRAM = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam int STATUS_PASS_FAIL_POS = 0;
  localparam int STATUS_READY_POS = 6;
  localparam int STATUS_UNPROTECTED_POS = 7;
  localparam int ADDR_CYCLES = 4;
  localparam int ERASE_ADDR_CYCLES = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 20;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_OP = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h5;
  localparam logic [1:0] OP_CMD = 2'h0;
  localparam logic [1:0] OP_ADDR = 2'h1;
  localparam logic [1:0] OP_DATA = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage
`default_nettype wire

// ---- src/nand_sync2.sv ----
// Two-flop synchroniser for pin inputs.
`default_nettype none
module nand_sync2 (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic d,
  output logic q
);
  logic meta;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // nand_sync2
`default_nettype wire

// ---- src/nand_host_ctrl.sv ----
// Host controller that drives a NAND flash through its strobe pins.
// Functional notes
// - Cycle type set by latch strobes; chip select low, read strobe high.
// - Codes 80,10,70,90,FF single cycle; erase is 60 then D0.
// - Host sends four address cycles (three for erase), column byte first; the controller sends one byte per OP_ADDR and does not count them.
// - Host trusts pass/fail bit only when ready bit set.
// - Host sends only 70h or FFh while device busy; address, data and read cycles go regardless of ready.
// - With shared ready line, host polls status per device.
`default_nettype none
module nand_host_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic cle,
  output logic ale,
  output logic ce_n,
  output logic we_n,
  output logic read_strobe_n,
  output logic wp_n,
  input wire logic ready_busy_n,
  input wire logic [7:0] data_bus_in,
  output logic [7:0] data_bus_out,
  output logic data_bus_oe
);
  typedef enum logic [1:0] {IDLE, SETUP, PULSE, HOLD} state_t;
  state_t state;
  logic [7:0] cmd_byte, addr_byte, wr_byte, rd_byte;
  logic [7:0] status_seen;
  logic [1:0] op;
  logic [3:0] cnt;
  logic busy_op, rb_sync, cmd_busy_ok, prot, pf_valid;
  wire logic [7:0] bus_sync;
  nand_sync2 u_rb (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(ready_busy_n),
    .q(rb_sync)
  );
  // Every bus bit passes two flops before the read byte is taken from it.
  for (genvar i = 0; i < 8; i++) begin : g_bus_sync
    nand_sync2 u_bit (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(data_bus_in[i]),
      .q(bus_sync[i])
    );
  end
  function automatic logic busy_allowed(input logic [7:0] c);
    busy_allowed = (c == nand_host_pkg::CMD_STATUS) || (c == nand_host_pkg::CMD_RESET);
  endfunction
  // Commands other than status or reset wait until ready.
  assign cmd_busy_ok = rb_sync || busy_allowed(cmd_byte);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= IDLE;
      cnt <= 4'h0;
      op <= nand_host_pkg::OP_CMD;
      busy_op <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          if (reg_wr && reg_addr == nand_host_pkg::REG_OP) begin
            op <= reg_wdata[1:0];
            busy_op <= 1'b1;
            state <= SETUP;
            cnt <= 4'h0;
          end
        end
        SETUP: begin
          if (op != nand_host_pkg::OP_CMD || cmd_busy_ok) begin
            state <= PULSE;
            cnt <= 4'h0;
          end
        end
        PULSE: begin
          if (cnt == 4'(nand_host_pkg::STROBE_CYCLES - 1)) begin
            state <= HOLD;
            cnt <= 4'h0;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        HOLD: begin
          if (cnt == 4'(nand_host_pkg::STROBE_CYCLES - 1)) begin
            state <= IDLE;
            busy_op <= 1'b0;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
  // Registered pin levels per cycle type; strobes low in each cycle that follows a PULSE cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cle <= 1'b0;
      ale <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      data_bus_out <= 8'h00;
      data_bus_oe <= 1'b0;
    end else begin
      ce_n <= !(state != IDLE);
      cle <= (state != IDLE) && op == nand_host_pkg::OP_CMD;
      ale <= (state != IDLE) && op == nand_host_pkg::OP_ADDR;
      we_n <= !(state == PULSE && op != nand_host_pkg::OP_READ);
      read_strobe_n <= !(state == PULSE && op == nand_host_pkg::OP_READ);
      data_bus_oe <= (state != IDLE) && op != nand_host_pkg::OP_READ;
      if (op == nand_host_pkg::OP_CMD) begin
        data_bus_out <= cmd_byte;
      end else if (op == nand_host_pkg::OP_ADDR) begin
        data_bus_out <= addr_byte;
      end else begin
        data_bus_out <= wr_byte;
      end
    end
  end
  // The read byte is taken from the synchronised bus at the end of the hold phase.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_byte <= 8'h00;
    end else if (state == HOLD && op == nand_host_pkg::OP_READ &&
                 cnt == 4'(nand_host_pkg::STROBE_CYCLES - 1)) begin
      rd_byte <= bus_sync;
    end
  end
  // Software-written bytes and write-protect control.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_byte <= nand_host_pkg::CTRL_RESET;
      addr_byte <= nand_host_pkg::CTRL_RESET;
      wr_byte <= nand_host_pkg::CTRL_RESET;
      prot <= 1'b1;
    end else if (reg_wr && !busy_op) begin
      if (reg_addr == nand_host_pkg::REG_CMD) begin
        cmd_byte <= reg_wdata;
      end else if (reg_addr == nand_host_pkg::REG_ADDR) begin
        addr_byte <= reg_wdata;
      end else if (reg_addr == nand_host_pkg::REG_WDATA) begin
        wr_byte <= reg_wdata;
      end else if (reg_addr == nand_host_pkg::REG_STAT) begin
        prot <= reg_wdata[0];
      end
    end
  end
  assign wp_n = !prot;
  // Pass/fail is trusted only when the read status shows ready.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_seen <= 8'h00;
    end else begin
      status_seen <= rd_byte;
    end
  end
  assign pf_valid = status_seen[nand_host_pkg::STATUS_READY_POS];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == nand_host_pkg::REG_RDATA) begin
        reg_rdata <= rd_byte;
      end else if (reg_addr == nand_host_pkg::REG_STAT) begin
        reg_rdata <= {4'h0, pf_valid && status_seen[nand_host_pkg::STATUS_PASS_FAIL_POS],
                      rb_sync, busy_op, prot};
      end else if (reg_addr == nand_host_pkg::REG_CMD) begin
        reg_rdata <= cmd_byte;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end
  a_we_pulse_len: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(we_n) |-> !we_n [*2] ##1 we_n) else $error("write strobe width wrong");
  a_cycle_type: assert property (@(posedge clk) disable iff (sys_rst)
    !we_n |-> !ce_n && read_strobe_n && !(cle && ale)) else $error("bad cycle");
  a_read_float: assert property (@(posedge clk) disable iff (sys_rst)
    !read_strobe_n |-> !data_bus_oe && !cle && !ale) else $error("bus driven in read");
  a_busy_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    (state == SETUP && op == nand_host_pkg::OP_CMD && !rb_sync &&
     !busy_allowed(cmd_byte)) |=> state == SETUP) else $error("cmd issued busy");
  a_idle_ce: assert property (@(posedge clk) disable iff (sys_rst)
    (state == IDLE) [*2] |-> ce_n) else $error("chip select left low");
  a_wp_follow: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(wp_n) |-> !busy_op) else $error("write protect moved in a cycle");
  a_cmd_out: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(we_n) && cle |-> data_bus_out == cmd_byte) else $error("cmd byte wrong");
  a_addr_out: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(we_n) && ale |-> data_bus_out == addr_byte) else $error("address byte wrong");
  a_hold_select: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(we_n) |-> !ce_n && $stable(data_bus_out)) else $error("byte moved at strobe");
  a_oe_select: assert property (@(posedge clk) disable iff (sys_rst)
    data_bus_oe |-> !ce_n) else $error("bus driven while deselected");
  a_rdata_cap: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(read_strobe_n) |=> rd_byte == $past(data_bus_in, 2)) else $error("read lost");
  c_cmd: cover property (@(posedge clk) $fell(we_n) && cle);
  c_addr: cover property (@(posedge clk) $fell(we_n) && ale);
  c_data: cover property (@(posedge clk) $fell(we_n) && !cle && !ale);
  c_read: cover property (@(posedge clk) $fell(read_strobe_n));
  c_busy_wait: cover property (@(posedge clk) state == SETUP && !cmd_busy_ok);
endmodule // nand_host_ctrl
`default_nettype wire

// ---- test/nand_flash_model.sv ----
// Behavioural model of the NAND flash device seen at the controller pins.
`default_nettype none
module nand_flash_model #(
  parameter int BUSY_NS = 2000,
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEVICE_ID = 8'hA5 // Arbitrary value.
) (
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  input wire logic [7:0] host_bus,
  input wire logic fail_next,
  output logic ready_busy_n,
  output logic [7:0] dev_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rb = 1'b1;
  logic fail = 1'b0;
  logic pend = 1'b0;
  logic drive = 1'b0;
  logic [7:0] q = 8'h00;
  int mode = 0;
  int ptr = 0;
  int idx = 0;
  int arm = 0;
  int naddr = 0;
  event go;
  assign ready_busy_n = rb;
  assign dev_bus = (drive && !ce_n) ? q : ~q;
  always begin : busy_blk
    @(go);
    rb = 1'b0;
    #(BUSY_NS);
    rb = 1'b1;
    fail = pend;
  end
  always @(posedge we_n) begin
    if (ce_n === 1'b0 && read_strobe_n === 1'b1) begin
      if (cle && !ale && (rb || host_bus == 8'h70 || host_bus == 8'hFF)) begin
        case (host_bus)
          8'h00, 8'h01, 8'h50: begin
            mode = 0;
            ptr = host_bus[0] ? 256 : (host_bus[6] ? 512 : 0);
          end
          8'h70: mode = 1;
          8'h90: begin
            mode = 2;
            idx = 0;
          end
          8'h10, 8'hD0: if (wp_n && (host_bus[7] ? arm == 2 && naddr == 3 : arm == 1)) begin
            fail = 1'b0;
            pend = fail_next;
            ->go;
          end
          8'hFF: begin
            disable busy_blk;
            rb = 1'b1;
          end
          default: ;
        endcase
        arm = host_bus == 8'h80 ? 1 : (host_bus == 8'h60 ? 2 : 0);
        naddr = 0;
      end else if (ale && !cle) begin
        naddr = naddr + 1;
      end else if (!wp_n) begin
        arm = 0;
      end
    end
  end
  always @(negedge read_strobe_n) begin
    if (ce_n === 1'b0 && !cle && !ale) begin
      q = mode == 2 ? (idx == 0 ? MAKER_ID : DEVICE_ID) : ptr[9:2];
      if (mode == 1) q = {wp_n, rb, 5'h00, fail};
      idx = idx + 1;
      ptr = ptr + 1;
      drive = 1'b1;
    end
  end
  always @(posedge read_strobe_n) drive = 1'b0;
endmodule // nand_flash_model
`default_nettype wire

// ---- test/nand_host_ctrl_test.sv ----
// Self-checking testbench of the NAND host controller against a device model.
`default_nettype none
module nand_host_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fail_next = 1'b0;
  logic [7:0] reg_rdata, data_bus_in, data_bus_out, g;
  logic cle, ale, ce_n, we_n, read_strobe_n, wp_n, ready_busy_n, data_bus_oe;
  logic [31:0] seed = 32'hb8d8_2fe7;
  int n_errors = 0;
  int samples_checked = 0;
  int k;
  localparam logic [7:0] MAKER_ID = 8'h5A; // Arbitrary value.
  localparam logic [7:0] DEVICE_ID = 8'hA5; // Arbitrary value.
  nand_host_ctrl dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cle, .ale, .ce_n, .we_n, .read_strobe_n, .wp_n, .ready_busy_n, .data_bus_in,
    .data_bus_out, .data_bus_oe);
  nand_flash_model #(.MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID)) dev_u (.cle, .ale, .ce_n,
    .we_n, .read_strobe_n, .wp_n, .host_bus(data_bus_out), .fail_next, .ready_busy_n,
    .dev_bus(data_bus_in));
  initial forever #5 clk = ~clk;
  function automatic logic [7:0] st(input int unprot, input int rdy, input int fl);
    return {unprot[0], rdy[0], 5'h00, fl[0]};
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic op(input logic [1:0] kd, input logic [7:0] b);
    logic [7:0] t;
    wr(kd == nand_host_pkg::OP_CMD ? nand_host_pkg::REG_CMD : (kd == nand_host_pkg::OP_ADDR ?
      nand_host_pkg::REG_ADDR : nand_host_pkg::REG_WDATA), b);
    wr(nand_host_pkg::REG_OP, {6'h00, kd});
    for (int j = 0; j < 400; j++) begin
      rd(nand_host_pkg::REG_STAT, t);
      if (t[1] === 1'b0) break;
    end
  endtask
  task automatic rnd(input logic [1:0] kd, input int n);
    repeat (n) begin
      seed = lfsr_next(seed);
      op(kd, seed[7:0]);
    end
  endtask
  task automatic get(output logic [7:0] d);
    op(nand_host_pkg::OP_READ, 8'h00);
    rd(nand_host_pkg::REG_RDATA, d);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'hF, g);
    chk(g, 8'h00);
    op(nand_host_pkg::OP_CMD, 8'h70);
    get(g);
    chk(g, st(0, 1, 0));
    wr(nand_host_pkg::REG_STAT, 8'h00);
    op(nand_host_pkg::OP_CMD, 8'h70);
    for (k = 0; k < 2; k++) begin
      get(g);
      chk(g, st(1, 1, 0));
    end
    op(nand_host_pkg::OP_CMD, 8'h90);
    get(g);
    chk(g, MAKER_ID);
    get(g);
    chk(g, DEVICE_ID);
    for (k = 0; k < 3; k++) begin
      op(nand_host_pkg::OP_CMD, k == 0 ? 8'h00 : (k == 1 ? 8'h01 : 8'h50));
      get(g);
      chk(g, 8'(k * 64));
    end
    op(nand_host_pkg::OP_CMD, 8'h80);
    rnd(nand_host_pkg::OP_ADDR, 4);
    rnd(nand_host_pkg::OP_DATA, 2);
    fail_next <= 1'b1;
    op(nand_host_pkg::OP_CMD, 8'h10);
    op(nand_host_pkg::OP_CMD, 8'h70);
    get(g);
    chk(g, st(1, 0, 0));
    op(nand_host_pkg::OP_CMD, 8'h00);
    get(g);
    chk(g, 8'h00);
    op(nand_host_pkg::OP_CMD, 8'h70);
    get(g);
    for (k = 0; k < 40 && g[6] !== 1'b1; k++) get(g);
    chk(g, st(1, 1, 1));
    rd(nand_host_pkg::REG_STAT, g);
    chk(g, 8'h0C);
    fail_next <= 1'b0;
    for (k = 2; k < 4; k++) begin
      op(nand_host_pkg::OP_CMD, 8'h60);
      rnd(nand_host_pkg::OP_ADDR, k);
      op(nand_host_pkg::OP_CMD, 8'hD0);
      op(nand_host_pkg::OP_CMD, 8'h70);
      get(g);
      chk(g, st(1, k == 2, k == 2));
    end
    op(nand_host_pkg::OP_CMD, 8'hFF);
    op(nand_host_pkg::OP_CMD, 8'h70);
    get(g);
    chk(g, st(1, 1, 0));
    wr(nand_host_pkg::REG_STAT, 8'h01);
    op(nand_host_pkg::OP_CMD, 8'h80);
    rnd(nand_host_pkg::OP_ADDR, 4);
    op(nand_host_pkg::OP_CMD, 8'h10);
    op(nand_host_pkg::OP_CMD, 8'h70);
    get(g);
    chk(g, st(0, 1, 0));
    tally_and_finish;
  end
endmodule // nand_host_ctrl_test
`default_nettype wire
